// File: uart_line_frame_control.v
// Line frame control for an asynchronous serial port, with a simple transmitter
// and receiver that obey the selected frame format.
// Assumes a plain register port from software and a remote serial peer on the line.
//
// Overview of operation
// - Divisors commit only on line control write
// - Stick parity with even select: parity zero
// - Stick parity with odd select: parity one
// - Word length field selects five to eight
// - FIFO bit set: multi-entry buffering
// - FIFO bit clear: one-byte holding register
// - Two-stop select appends two stop bits
// - Receiver never checks second stop bit
// - Even parity: even count of ones
// - Odd parity: odd count of ones
// - Even select ignored without parity enable
// - Parity enable adds and checks parity
// - Break holds line low after character
// - New divisor waits for character end
// - Clearing FIFO bit flushes transmit FIFO
`timescale 1ns/100ps
`include "uart_lfc_consts.vh"
module uart_line_frame_control
#(
   parameter FIFO_DEPTH = `LFC_FIFO_DEPTH
)
(
   input  wire        core_clk,
   input  wire        arst_n,
   input  wire [11:0] reg_addr,
   input  wire [31:0] reg_wdata,
   input  wire        reg_write,
   input  wire        reg_read,
   output reg  [31:0] reg_rdata,
   input  wire        serial_rx_in,
   output wire        serial_tx_out,
   output wire        divisor_load,
   output wire        tx_flush
);
   // ----------------------------------------
   // Registers and decode
   // ----------------------------------------
   reg  [`LFC_CTRL_WIDTH-1:0]     ctrl_reg;       // Line frame control
   reg  [`LFC_INT_DIV_WIDTH-1:0]  int_stage_reg;  // Integer divisor as written
   reg  [`LFC_FRAC_DIV_WIDTH-1:0] frac_stage_reg; // Fraction as written
   reg  [`LFC_INT_DIV_WIDTH-1:0]  int_cmt_reg;    // Committed integer divisor
   reg  [`LFC_FRAC_DIV_WIDTH-1:0] frac_cmt_reg;   // Committed fraction
   reg                            cmt_pend_reg;   // Commit awaiting idle line
   reg  [`LFC_INT_DIV_WIDTH-1:0]  int_act_reg;    // Divisor in use
   reg  [`LFC_FRAC_DIV_WIDTH-1:0] frac_act_reg;   // Fraction in use
   wire                           wr_ctrl;        // Line control write
   wire                           tx_busy;        // Character on the line
   wire                           rx_busy;        // Character arriving
   wire [`LFC_CTRL_WIDTH-1:0]     ctrl_next;      // Masked write value

   assign wr_ctrl      = reg_write && (reg_addr == `LFC_ADDR_LINE_CTRL);
   assign ctrl_next    = reg_wdata[`LFC_CTRL_WIDTH-1:0];
   assign divisor_load = wr_ctrl;
   // Flush when the FIFO bit goes from set to clear
   assign tx_flush     = wr_ctrl && ctrl_reg[`LFC_FIFO_BIT] && !ctrl_next[`LFC_FIFO_BIT];

   // Word length decode used by both directions
   function [3:0] data_bits;
      input [1:0] data_word_length;
      begin
         case (data_word_length)
            `LFC_DATA_WORD_LENGTH_8: data_bits = 4'h8;
            `LFC_DATA_WORD_LENGTH_7: data_bits = 4'h7;
            `LFC_DATA_WORD_LENGTH_6: data_bits = 4'h6;
            default:     data_bits = 4'h5;
         endcase
      end
   endfunction

   // Parity bit for a data word under current settings
   function parity_of;
      input [7:0] d;
      input [7:0] c;
      reg   [7:0] m;
      reg   [3:0] n;
      begin
         m = d;
         n = data_bits(c[`LFC_DATA_WORD_LENGTH_HI:`LFC_DATA_WORD_LENGTH_LO]);
         if (n < 4'h8) m[7] = 1'b0;
         if (n < 4'h7) m[6] = 1'b0;
         if (n < 4'h6) m[5] = 1'b0;
         if (c[`LFC_SPS_BIT])
            parity_of = ~c[`LFC_EPS_BIT];
         else if (c[`LFC_EPS_BIT])
            parity_of = ^m;
         else
            parity_of = ~(^m);
      end
   endfunction

   // Register writes; reserved bits are simply not stored
   always @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         ctrl_reg       <= `LFC_CTRL_RESET;
         int_stage_reg  <= `LFC_INT_DIV_RESET;
         frac_stage_reg <= `LFC_FRAC_DIV_RESET;
         int_cmt_reg    <= `LFC_INT_DIV_RESET;
         frac_cmt_reg   <= `LFC_FRAC_DIV_RESET;
      end
      else if (reg_write)
      begin
         if (reg_addr == `LFC_ADDR_INT_DIV)
            int_stage_reg <= reg_wdata[`LFC_INT_DIV_WIDTH-1:0];
         if (reg_addr == `LFC_ADDR_FRAC_DIV)
            frac_stage_reg <= reg_wdata[`LFC_FRAC_DIV_WIDTH-1:0];
         if (wr_ctrl)
         begin
            ctrl_reg     <= ctrl_next;
            int_cmt_reg  <= int_stage_reg;
            frac_cmt_reg <= frac_stage_reg;
         end
      end
   end

   // Committed divisor applied only between characters
   always @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         cmt_pend_reg <= 1'b0;
         int_act_reg  <= `LFC_INT_DIV_RESET;
         frac_act_reg <= `LFC_FRAC_DIV_RESET;
      end
      else if (cmt_pend_reg && !tx_busy && !rx_busy)
      begin
         int_act_reg  <= int_cmt_reg;
         frac_act_reg <= frac_cmt_reg;
         cmt_pend_reg <= wr_ctrl;
      end
      else if (wr_ctrl)
         cmt_pend_reg <= 1'b1;
   end

   // ----------------------------------------
   // Baud tick: 16x oversample from divisor
   // ----------------------------------------
   reg  [`LFC_INT_DIV_WIDTH+`LFC_FRAC_DIV_WIDTH-1:0] baud_cnt_reg; // Fixed-point count
   wire [`LFC_INT_DIV_WIDTH+`LFC_FRAC_DIV_WIDTH-1:0] baud_top;     // Reload point
   wire                                              tick;         // Oversample strike
   // Fraction is shifted out and ignored; only the integer divisor sets the tick period
   assign baud_top = {int_act_reg, frac_act_reg} >> `LFC_FRAC_DIV_WIDTH;
   assign tick     = (baud_cnt_reg >= baud_top);

   // Free running divider
   always @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
         baud_cnt_reg <= {(`LFC_INT_DIV_WIDTH+`LFC_FRAC_DIV_WIDTH){1'b0}};
      else if (tick)
         baud_cnt_reg <= {(`LFC_INT_DIV_WIDTH+`LFC_FRAC_DIV_WIDTH){1'b0}};
      else
         baud_cnt_reg <= baud_cnt_reg + {{(`LFC_INT_DIV_WIDTH+`LFC_FRAC_DIV_WIDTH-1){1'b0}}, 1'b1};
   end

   // ----------------------------------------
   // Transmit and receive FIFOs and software data port
   // ----------------------------------------
   wire       txf_in_ready;  // Room in transmit buffer
   wire       txf_valid;     // Word waiting to go
   wire [7:0] txf_data;      // Head word
   reg        tx_take;       // Transmitter pulls a word
   wire [3:0] buf_limit;     // Depth per mode
   wire       rxf_in_ready;  // Room in receive buffer
   wire       rxf_valid;     // Received word present
   wire [7:0] rxf_data;      // Oldest received word
   reg  [7:0] rx_word_reg;   // Word being assembled
   reg        rx_push;       // Receiver delivers a word
   wire       rx_pop;        // Software read of data

   // Character mode shrinks both buffers to one entry
   assign buf_limit = ctrl_reg[`LFC_FIFO_BIT] ? FIFO_DEPTH[3:0] : 4'h1;
   assign rx_pop    = reg_read && (reg_addr == `LFC_ADDR_DATA);

   lfc_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH), .AW(3)) u_tx_fifo
   (
      .core_clk  (core_clk),
      .arst_n    (arst_n),
      .flush     (tx_flush),
      .limit     (buf_limit),
      .in_valid  (reg_write && (reg_addr == `LFC_ADDR_DATA)),
      .in_ready  (txf_in_ready),
      .in_data   (reg_wdata[7:0]),
      .out_valid (txf_valid),
      .out_ready (tx_take),
      .out_data  (txf_data)
   );

   lfc_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH), .AW(3)) u_rx_fifo
   (
      .core_clk  (core_clk),
      .arst_n    (arst_n),
      .flush     (1'b0),
      .limit     (buf_limit),
      .in_valid  (rx_push),
      .in_ready  (rxf_in_ready),
      .in_data   (rx_word_reg),
      .out_valid (rxf_valid),
      .out_ready (rx_pop),
      .out_data  (rxf_data)
   );

   // ----------------------------------------
   // Transmitter
   // ----------------------------------------
   localparam TX_IDLE = 4'b0001;
   localparam TX_SEND = 4'b0010;
   localparam TX_BRK  = 4'b0100;
   localparam TX_GAP  = 4'b1000;
   reg  [3:0]  tx_state_reg;   // One-hot state
   reg  [11:0] tx_shift_reg;   // Start, data, parity, stops
   reg  [3:0]  tx_left_reg;    // Bits still to send
   reg  [3:0]  tx_sub_reg;     // Ticks within a bit
   reg         tx_line_reg;    // Registered line level
   assign serial_tx_out = tx_line_reg;
   assign tx_busy       = !tx_state_reg[0];

   // Frame builder and bit serialiser
   always @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         tx_state_reg <= TX_IDLE;
         tx_shift_reg <= 12'hfff;
         tx_left_reg  <= 4'h0;
         tx_sub_reg   <= 4'h0;
         tx_line_reg  <= 1'b1;
         tx_take      <= 1'b0;
      end
      else
      begin
         tx_take <= 1'b0;
         case (tx_state_reg)
            TX_IDLE:
            begin
               tx_line_reg <= 1'b1;
               if (ctrl_reg[`LFC_BRK_BIT])
                  tx_state_reg <= TX_BRK;
               else if (txf_valid && !tx_take && !cmt_pend_reg)
               begin
                  // Start low then data LSB first, parity, high stops
                  tx_shift_reg <= {3'h7, txf_data, 1'b0} | (12'hfff << (data_bits(ctrl_reg[6:5]) + 4'h1));
                  if (ctrl_reg[`LFC_PEN_BIT])
                     tx_shift_reg[data_bits(ctrl_reg[6:5]) + 4'h1] <= parity_of(txf_data, ctrl_reg);
                  tx_left_reg  <= data_bits(ctrl_reg[6:5]) + 4'h2 + {3'h0, ctrl_reg[`LFC_PEN_BIT]}
                                  + {3'h0, ctrl_reg[`LFC_TWO_STOP_SELECT_BIT]};
                  tx_take      <= 1'b1;
                  tx_sub_reg   <= 4'h0;
                  tx_state_reg <= TX_SEND;
               end
            end
            TX_SEND:
            begin
               tx_line_reg <= tx_shift_reg[0];
               if (tick)
               begin
                  tx_sub_reg <= tx_sub_reg + 4'h1;
                  if (tx_sub_reg == `LFC_SAMPLE_TICKS)
                  begin
                     tx_shift_reg <= {1'b1, tx_shift_reg[11:1]};
                     tx_left_reg  <= tx_left_reg - 4'h1;
                     if (tx_left_reg == 4'h1)
                        tx_state_reg <= TX_GAP;
                  end
               end
            end
            TX_GAP:
            begin
               // One idle cycle so the next head word is settled
               tx_line_reg  <= 1'b1;
               tx_state_reg <= TX_IDLE;
            end
            TX_BRK:
            begin
               // Break length is software's duty; held until cleared
               tx_line_reg <= 1'b0;
               if (!ctrl_reg[`LFC_BRK_BIT])
                  tx_state_reg <= TX_GAP;
            end
            default:
               tx_state_reg <= TX_IDLE;
         endcase
      end
   end

   // ----------------------------------------
   // Receiver
   // ----------------------------------------
   localparam RX_IDLE = 3'b001;
   localparam RX_BITS = 3'b010;
   localparam RX_STOP = 3'b100;
   reg  [1:0] rx_sync_reg;   // Two-stage pin synchroniser
   reg  [2:0] rx_state_reg;  // One-hot state
   reg  [3:0] rx_sub_reg;    // Ticks within a bit
   reg  [3:0] rx_idx_reg;    // Bit index after start
   reg        rx_par_reg;    // Received parity bit
   reg        par_err_reg;   // Last parity mismatch
   reg        frm_err_reg;   // Last missing stop bit
   reg        ovr_err_reg;   // Word lost to full buffer
   wire       rx_pin;        // Synchronised line
   assign rx_pin  = rx_sync_reg[1];
   assign rx_busy = !rx_state_reg[0];

   // Line synchroniser
   always @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
         rx_sync_reg <= 2'h3;
      else
         rx_sync_reg <= {rx_sync_reg[0], serial_rx_in};
   end

   // Start detect, mid-bit sampling, checks
   always @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rx_state_reg <= RX_IDLE;
         rx_sub_reg   <= 4'h0;
         rx_idx_reg   <= 4'h0;
         rx_word_reg  <= 8'h00;
         rx_par_reg   <= 1'b0;
         rx_push      <= 1'b0;
         par_err_reg  <= 1'b0;
         frm_err_reg  <= 1'b0;
         ovr_err_reg  <= 1'b0;
      end
      else
      begin
         rx_push <= 1'b0;
         case (rx_state_reg)
            RX_IDLE:
               if (!rx_pin)
               begin
                  rx_sub_reg   <= `LFC_MID_TICKS;
                  rx_idx_reg   <= 4'h0;
                  rx_word_reg  <= 8'h00;
                  rx_state_reg <= RX_BITS;
               end
            RX_BITS:
               if (tick)
               begin
                  rx_sub_reg <= rx_sub_reg + 4'h1;
                  if (rx_sub_reg == `LFC_SAMPLE_TICKS)
                  begin
                     rx_idx_reg <= rx_idx_reg + 4'h1;
                     if (rx_idx_reg == 4'h0 && rx_pin)
                        rx_state_reg <= RX_IDLE; // Glitch, not a start
                     else if (rx_idx_reg != 4'h0 && rx_idx_reg <= data_bits(ctrl_reg[6:5]))
                        rx_word_reg[rx_idx_reg[2:0] - 3'h1] <= rx_pin;
                     else if (rx_idx_reg != 4'h0 && ctrl_reg[`LFC_PEN_BIT] && !rx_state_reg[2]
                              && rx_idx_reg == data_bits(ctrl_reg[6:5]) + 4'h1)
                        rx_par_reg <= rx_pin;
                     else if (rx_idx_reg != 4'h0)
                     begin
                        // First stop only; a second stop is never examined
                        frm_err_reg  <= !rx_pin;
                        rx_state_reg <= RX_STOP;
                     end
                  end
               end
            RX_STOP:
            begin
               if (ctrl_reg[`LFC_PEN_BIT])
                  par_err_reg <= (rx_par_reg != parity_of(rx_word_reg, ctrl_reg));
               else
                  par_err_reg <= 1'b0;
               rx_push      <= rxf_in_ready;
               ovr_err_reg  <= ovr_err_reg | !rxf_in_ready;
               rx_state_reg <= RX_IDLE;
            end
            default:
               rx_state_reg <= RX_IDLE;
         endcase
      end
   end

   // ----------------------------------------
   // Read data, one cycle after the strobe
   // ----------------------------------------
   always @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
         reg_rdata <= 32'h00000000;
      else if (!reg_read)
         reg_rdata <= 32'h00000000;
      else
      case (reg_addr)
         `LFC_ADDR_LINE_CTRL: reg_rdata <= {24'h000000, ctrl_reg};
         `LFC_ADDR_INT_DIV:   reg_rdata <= {16'h0000, int_stage_reg};
         `LFC_ADDR_FRAC_DIV:  reg_rdata <= {26'h0000000, frac_stage_reg};
         `LFC_ADDR_DATA:      reg_rdata <= {21'h000000, ovr_err_reg, frm_err_reg, par_err_reg, rxf_data};
         `LFC_ADDR_STATUS:    reg_rdata <= {25'h0000000, cmt_pend_reg, !txf_in_ready, txf_valid,
                                            rxf_valid, tx_busy, ctrl_reg[`LFC_BRK_BIT], rx_busy};
         default:             reg_rdata <= 32'h00000000;
      endcase
   end
endmodule

// File: uart_lfc_consts.vh
// Constants for the line frame control block: offsets, field positions, widths.
// Assumes inclusion by bare name from the design files of this block.
`ifndef UART_LFC_CONSTS_VH
`define UART_LFC_CONSTS_VH
// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define LFC_ADDR_INT_DIV     12'h024
`define LFC_ADDR_FRAC_DIV    12'h028
`define LFC_ADDR_LINE_CTRL   12'h02c
`define LFC_ADDR_STATUS      12'h018
`define LFC_ADDR_DATA        12'h000
// ----------------------------------------
// Line frame control fields
// ----------------------------------------
`define LFC_BRK_BIT          0
`define LFC_PEN_BIT          1
`define LFC_EPS_BIT          2
`define LFC_TWO_STOP_SELECT_BIT         3
`define LFC_FIFO_BIT         4
`define LFC_DATA_WORD_LENGTH_LO          5
`define LFC_DATA_WORD_LENGTH_HI          6
`define LFC_SPS_BIT          7
`define LFC_CTRL_WIDTH       8
`define LFC_CTRL_RESET       8'h00
// ----------------------------------------
// Word length codes and widths
// ----------------------------------------
`define LFC_DATA_WORD_LENGTH_5           2'h0
`define LFC_DATA_WORD_LENGTH_6           2'h1
`define LFC_DATA_WORD_LENGTH_7           2'h2
`define LFC_DATA_WORD_LENGTH_8           2'h3
`define LFC_INT_DIV_WIDTH    16
`define LFC_FRAC_DIV_WIDTH   6
`define LFC_INT_DIV_RESET    16'h0000
`define LFC_FRAC_DIV_RESET   6'h00
`define LFC_FIFO_DEPTH       8
`define LFC_BIT_CNT_WIDTH    4
`define LFC_SAMPLE_TICKS     4'hf
`define LFC_MID_TICKS        4'h7
`endif

// File: lfc_fifo.v
// Small synchronous FIFO with valid/ready on both sides and a flush input.
// Assumes one clock and an active-low asynchronous reset shared with its user.
`timescale 1ns/100ps
module lfc_fifo
#(
   parameter WIDTH = 8,
   parameter DEPTH = 8,
   parameter AW    = 3
)
(
   input  wire             core_clk,
   input  wire             arst_n,
   input  wire             flush,
   input  wire [AW:0]      limit,
   input  wire             in_valid,
   output wire             in_ready,
   input  wire [WIDTH-1:0] in_data,
   output wire             out_valid,
   input  wire             out_ready,
   output wire [WIDTH-1:0] out_data
);
   // ----------------------------------------
   // Storage and pointers
   // ----------------------------------------
   reg  [WIDTH-1:0] mem_reg [0:DEPTH-1];   // Data words
   reg  [AW-1:0]    wr_ptr_reg;            // Write index
   reg  [AW-1:0]    rd_ptr_reg;            // Read index
   reg  [AW:0]      count_reg;             // Fill level
   wire             push;                  // Word taken in
   wire             pop;                   // Word handed out

   // Limit lets the user shrink the FIFO to one holding register;
   // a word leaving frees its slot in the same cycle
   assign in_ready  = (count_reg < limit) || out_ready;
   assign out_valid = (count_reg != {(AW+1){1'b0}});
   assign out_data  = mem_reg[rd_ptr_reg];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   // Pointer and count update; flush empties without touching data
   always @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         wr_ptr_reg <= {AW{1'b0}};
         rd_ptr_reg <= {AW{1'b0}};
         count_reg  <= {(AW+1){1'b0}};
      end
      else if (flush)
      begin
         wr_ptr_reg <= {AW{1'b0}};
         rd_ptr_reg <= {AW{1'b0}};
         count_reg  <= {(AW+1){1'b0}};
      end
      else
      begin
         if (push)
            wr_ptr_reg <= wr_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
         if (pop)
            rd_ptr_reg <= rd_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
         if (push && !pop)
            count_reg <= count_reg + {{AW{1'b0}}, 1'b1};
         else if (pop && !push)
            count_reg <= count_reg - {{AW{1'b0}}, 1'b1};
      end
   end

   // Data array has no reset; out_data shows mem_reg[rd_ptr_reg] even while the FIFO is empty
   always @(posedge core_clk)
   begin
      if (push)
         mem_reg[wr_ptr_reg] <= in_data;
   end
endmodule

// File: uart_line_frame_control_asserts.sv
// Checker for the line frame control block's ports.
// Assumes one clock; bound in below.
`timescale 1ns/100ps
module uart_line_frame_control_checker
(
   input wire        core_clk,
   input wire        arst_n,
   input wire [11:0] reg_addr,
   input wire [31:0] reg_wdata,
   input wire        reg_write,
   input wire        reg_read,
   input wire [31:0] reg_rdata,
   input wire        serial_tx_out,
   input wire        divisor_load,
   input wire        tx_flush
);
   // ----------------------------------------
   // Helper logic
   // ----------------------------------------
   logic [7:0]  ctrl_reg;           // Shadow of the writable control fields
   logic [10:0] brk_cnt_reg;        // Cycles spent with break requested
   wire         ctrl_wr = reg_write && (reg_addr == 12'h02c);

   // Shadow and break counter; counter saturates so it never wraps
   always @(posedge core_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         ctrl_reg    <= 8'h00;
         brk_cnt_reg <= 11'h000;
      end
      else
      begin
         if (ctrl_wr)
            ctrl_reg <= reg_wdata[7:0];
         if (!ctrl_reg[0])
            brk_cnt_reg <= 11'h000;
         else if (brk_cnt_reg != 11'h7ff)
            brk_cnt_reg <= brk_cnt_reg + 11'h001;
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!arst_n);

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   chk_div_commit: assert property (divisor_load == ctrl_wr)
      else $error("divisor commit pulse does not match a control write");
   chk_flush_pulse: assert property (tx_flush == (ctrl_wr && ctrl_reg[4] && !reg_wdata[4]))
      else $error("flush pulse does not match clearing of the fifo bit");
   chk_rdata_idle: assert property (!reg_read |=> reg_rdata == 32'h0)
      else $error("read data not zero outside a read answer");
   chk_ctrl_readback: assert property (reg_read && ctrl_wr == 1'b0 && reg_addr == 12'h02c |=>
      reg_rdata == {24'h000000, ctrl_reg}) else $error("control readback wrong");
   chk_unmapped_zero: assert property (reg_read && reg_addr > 12'h030 |=> reg_rdata == 32'h0)
      else $error("unmapped read not zero");
   // Longest frame at small divisors fits well inside this count
   chk_brk_hold: assert property (brk_cnt_reg >= 11'h320 |-> !serial_tx_out)
      else $error("line not low while break held");
   chk_start_width: assert property ($fell(serial_tx_out) |-> !serial_tx_out [*8])
      else $error("start bit too short");
   chk_reset_idle: assert property ($rose(arst_n) |-> serial_tx_out)
      else $error("line not idle high after reset");
endmodule

bind uart_line_frame_control uart_line_frame_control_checker i_chk (.*);

// File: uart_lfc_peer.sv
// Remote serial peer: sends and samples frames.
// Assumes an idle-high line; bit time given per call.
`timescale 1ns/100ps
module uart_lfc_peer
(
   input  wire  core_clk,
   input  wire  line_in,
   output logic line_out
);
   initial line_out = 1'b1;         // Idle high between frames

   // Start bit, then n bits LSB first, then back to idle
   task automatic send_frame(input logic [15:0] bits, input int n, input int bit_cyc);
      line_out <= 1'b0;
      repeat (bit_cyc) @(posedge core_clk);
      for (int i = 0; i < n; i++)
      begin
         line_out <= bits[i];
         repeat (bit_cyc) @(posedge core_clk);
      end
      line_out <= 1'b1;
   endtask

   // Waits for a start bit, samples n bits at mid-bit, start excluded
   task automatic recv_frame(output logic [15:0] bits, input int n, input int bit_cyc);
      bits = 16'h0000;
      while (line_in !== 1'b0)
         @(posedge core_clk);
      repeat (bit_cyc / 2) @(posedge core_clk);
      for (int i = 0; i < n; i++)
      begin
         repeat (bit_cyc) @(posedge core_clk);
         bits[i] = line_in;
      end
   endtask
endmodule

// File: uart_line_frame_control_tb.sv
// Testbench: register tasks, serial peer, compares.
// Assumes divisor zero at reset: 16 cycles a bit.
`timescale 1ns/100ps
module uart_line_frame_control_tb;
   logic        core_clk;
   logic        arst_n;
   logic [11:0] reg_addr;
   logic [31:0] reg_wdata;
   logic        reg_write;
   logic        reg_read;
   wire  [31:0] reg_rdata;
   wire         serial_rx_in;
   wire         serial_tx_out;
   int          fail_count;
   int          checks_done;
   int          cycle_cnt;
   logic [31:0] rd;
   logic [15:0] bits;
   logic [7:0]  fmt [8] = '{8'h00, 8'h62, 8'h46, 8'h2a, 8'h86, 8'h82, 8'h64, 8'h78};

   uart_line_frame_control #(.FIFO_DEPTH(8)) i_dut (.*, .divisor_load(), .tx_flush());
   uart_lfc_peer peer (.core_clk(core_clk), .line_in(serial_tx_out), .line_out(serial_rx_in));

   initial
   begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end

   // ----------------------------------------
   // Expected frames
   // ----------------------------------------
   function automatic int frame_len(input logic [7:0] c);
      return 5 + c[6:5] + c[1] + 1 + c[3];
   endfunction
   function automatic logic [7:0] dmask(input logic [7:0] d, input logic [7:0] c);
      return d & (8'hff >> (3 - c[6:5]));
   endfunction
   // Data, then parity if enabled, then high stop bits, cut to frame length
   function automatic logic [15:0] frame_bits(input logic [7:0] d, input logic [7:0] c);
      logic [7:0]  m;
      logic [15:0] f;
      m = dmask(d, c);
      f = {8'h00, m} | (16'hffff << (5 + c[6:5]));
      if (c[1])
         f[5 + c[6:5]] = c[7] ? ~c[2] : (c[2] ? ^m : ~^m);
      return f & ~(16'hffff << frame_len(c));
   endfunction

   // ----------------------------------------
   // Bus tasks and compare
   // ----------------------------------------
   task automatic reg_wr(input logic [11:0] a, input logic [31:0] d);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge core_clk);
      reg_write <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic reg_rd(input logic [11:0] a, output logic [31:0] d);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge core_clk);
      reg_read <= 1'b0;
      #1 d = reg_rdata;
      @(posedge core_clk);
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         fail_count++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // Hang guard: about four times the expected run
   always @(posedge core_clk)
   begin
      cycle_cnt++;
      if (cycle_cnt == 32'h0000_4e20)
      begin
         fail_count++;
         final_report();
      end
   end

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      {arst_n, reg_addr, reg_wdata, reg_write, reg_read} = '0;
      repeat (4) @(posedge core_clk);
      arst_n <= 1'b1;
      @(posedge core_clk);
      reg_rd(12'h02c, rd);
      check(rd, 32'h0);
      reg_wr(12'h02c, 32'hffff_ff00);
      reg_rd(12'h02c, rd);
      check(rd, 32'h0);
      reg_rd(12'h0fc, rd);
      check(rd, 32'h0);
      // Every word length, parity mode and stop count, both directions
      foreach (fmt[k])
      begin
         reg_wr(12'h02c, {24'h0, fmt[k]});
         reg_wr(12'h000, {24'h0, fmt[k] ^ 8'h5a});
         peer.recv_frame(bits, frame_len(fmt[k]), 16);
         check({16'h0, bits}, {16'h0, frame_bits(fmt[k] ^ 8'h5a, fmt[k])});
         peer.send_frame(frame_bits(fmt[k] ^ 8'h5a, fmt[k]), frame_len(fmt[k]), 16);
         repeat (40) @(posedge core_clk);
         reg_rd(12'h000, rd);
         check({21'h0, rd[10:0]}, {24'h0, dmask(fmt[k] ^ 8'h5a, fmt[k])});
      end
      // Flipped parity bit must be flagged
      reg_wr(12'h02c, 32'h46);
      peer.send_frame(frame_bits(8'h33, 8'h46) ^ 16'h0080, 9, 16);
      repeat (40) @(posedge core_clk);
      reg_rd(12'h000, rd);
      check({30'h0, rd[9:8]}, 32'h1);
      // Buffer depth: one in character mode, eight in fifo mode
      for (int k = 0; k < 2; k++)
      begin
         reg_wr(12'h02c, k ? 32'h70 : 32'h60);
         // Peer must be waiting before the first start bit
         fork
            begin
               for (int i = 0; i <= (k ? 9 : 2); i++)
                  reg_wr(12'h000, i);
               reg_rd(12'h018, rd);
               check({30'h0, rd[5:4]}, 32'h3);
               reg_wr(12'h02c, 32'h60);
               reg_rd(12'h018, rd);
               check({31'h0, rd[4]}, {31'h0, k == 0});
            end
            for (int i = 0; i <= (k ? 0 : 1); i++)
            begin
               peer.recv_frame(bits, 9, 16);
               check({24'h0, bits[7:0]}, i);
            end
         join
         repeat (200) @(posedge core_clk);
      end
      // Break asked in mid-character: character ends, then line low
      reg_wr(12'h000, 32'h3c);
      reg_wr(12'h02c, 32'h61);
      peer.recv_frame(bits, 9, 16);
      check({16'h0, bits}, 32'h13c);
      repeat (900) @(posedge core_clk);
      check({31'h0, serial_tx_out}, 32'h0);
      reg_wr(12'h02c, 32'h60);
      repeat (20) @(posedge core_clk);
      check({31'h0, serial_tx_out}, 32'h1);
      // Divisor staged, applied by the control write
      reg_wr(12'h024, 32'h1);
      reg_rd(12'h024, rd);
      check(rd, 32'h1);
      reg_wr(12'h02c, 32'h60);
      reg_wr(12'h000, 32'ha6);
      peer.recv_frame(bits, 9, 32);
      check({16'h0, bits}, 32'h1a6);
      final_report();
   end
endmodule
